// ===== core/sic_top.sv
// Function
// - hold 24-bit short I/O address base
// - scratch words read back unchanged
// - debug clock always on or tap-gated
// - dma off, run, run+wait, or all
// - locked dma variant freezes field until reset
// - i2c trigger from controller or target
// - readable normal or fast speed mode
// - bit reorders adc scan control bits
// - select which interval timer is master
// - flag cause of most recent reset
// - external flag when pin outlasts power-on
// - stop entry control with lock variants
// - wait entry control with lock variants
// - 1.2v regulator normal/standby, lockable
// - 2.7v regulator normal/standby/powerdown
// - one cause shown, fixed priority order
// - fast 4:4:1, normal 2:2:1 clock ratio
// - timer zero or timer one master
//
// The register addresses and the strobed register port were decided locally.
`timescale 1ns/1ns
`default_nettype none
`include "sic_defs.svh"

module sic_top
    import sic_pkg::*;
(
    // clock and reset
    input wire logic i_clk_sys,
    input wire logic i_rst_n,
    // register port
    input wire sic_pkg::sic_bus_req_t i_bus,
    output var logic [`SIC_DATA_W-1:0] o_rdata,
    // chip status inputs
    input wire sic_pkg::sic_pwr_mode_t i_pwr_mode,
    input wire logic i_tap_en,
    input wire logic i_fast_mode,
    // reset sources, levels seen while reset is held
    input wire logic i_por,
    input wire logic i_ext_rst_pin,
    input wire logic i_wd_ref_loss,
    input wire logic i_wd_cpu_tmo,
    input wire logic i_sw_rst,
    input wire logic i_wd_win_tmo,
    // settings to the rest of the chip
    output var sic_pkg::sic_out_t o_ctl
);
    import sic_pkg::*;

    // ==========================================================
    // state
    typedef struct packed {
        logic [`SIC_SCR_N-1:0][`SIC_DATA_W-1:0] scr; // scratch words
        logic dbg_always;         // debug clock free running
        sic_dma_mode_t dma_mode;  // dma behaviour
        logic dma_lock;           // dma field frozen
        logic stop_blk;           // stop instruction ignored
        logic stop_lock;
        logic wait_blk;           // wait instruction ignored
        logic wait_lock;
        logic sr12_lock;
        logic sr27_lock;
        logic [5:0] pend;         // causes seen during reset
        logic rel;                // capture done after release
        logic [`SIC_DATA_W-1:0] rdata;
        sic_out_t out;
    } sic_state_t;

    sic_state_t st_reg; // registered state
    sic_state_t st_next; // next state
    logic [5:0] src; // raw reset sources

    assign src = {i_wd_win_tmo, i_sw_rst, i_wd_cpu_tmo, i_wd_ref_loss,
                  i_ext_rst_pin, i_por};

    // ==========================================================
    // helpers
    // address falls in the scratch window
    function automatic logic is_scr(input logic [`SIC_ADDR_W-1:0] a);
        return (a >= `SIC_OFS_SCR0) &&
               (a < `SIC_OFS_SCR0 + 5'(`SIC_SCR_N));
    endfunction

    // keep only the highest ranked cause, lowest bit wins
    function automatic logic [5:0] pick_cause(input logic [5:0] p);
        pick_cause = 6'h00;
        for (int k = 5; k >= 0; k--) begin
            if (p[k]) begin
                pick_cause = 6'h01 << k;
            end
        end
    endfunction

    // ==========================================================
    // next state
    always_comb begin
        logic [2:0] idx;
        idx = 3'(i_bus.addr - `SIC_OFS_SCR0);
        st_next = st_reg;
        st_next.rdata = `SIC_DATA_W'(0);
        // power-on wipes the history, so a pin still held after it
        // is what remains recorded
        if (!i_rst_n) begin
            if (i_por) begin
                st_next.pend = `SIC_CAUSE_POR;
            end else if (i_ext_rst_pin) begin
                // pin outlasting power-on replaces the power-on flag
                st_next.pend = (st_reg.pend | src) & ~`SIC_CAUSE_POR;
            end else begin
                st_next.pend = st_reg.pend | src;
            end
        end
        if (!i_rst_n) begin
            // every setting returns to default and every lock opens
            st_next.scr = '0;
            for (int k = 0; k < `SIC_SCR_N; k++) begin
                st_next.scr[k] = `SIC_RST_SCR;
            end
            st_next.dbg_always = 1'b0;
            st_next.dma_mode = SIC_DMA_OFF;
            st_next.dma_lock = 1'b0;
            st_next.stop_blk = 1'b0;
            st_next.stop_lock = 1'b0;
            st_next.wait_blk = 1'b0;
            st_next.wait_lock = 1'b0;
            st_next.sr12_lock = 1'b0;
            st_next.sr27_lock = 1'b0;
            st_next.rel = 1'b0;
            st_next.out = '0;
            st_next.out.io_base = `SIC_RST_IO_BASE;
            st_next.out.cause = `SIC_RST_CAUSE;
            st_next.out.core_flash_div = `SIC_DIV_NORMAL;
        end else begin
            // first cycle after release latches one cause
            if (!st_reg.rel) begin
                st_next.out.cause = pick_cause(st_reg.pend);
                st_next.pend = 6'h00;
                st_next.rel = 1'b1;
            end
            // register writes, address decode
            if (i_bus.wr) begin
                if (i_bus.addr == `SIC_OFS_IO_LO) begin
                    st_next.out.io_base[15:0] = i_bus.wdata;
                end else if (i_bus.addr == `SIC_OFS_IO_HI) begin
                    st_next.out.io_base[23:16] = i_bus.wdata[7:0];
                end else if (is_scr(i_bus.addr)) begin
                    st_next.scr[idx] = i_bus.wdata;
                end else if (i_bus.addr == `SIC_OFS_CTRL) begin
                    st_next.dbg_always = i_bus.wdata[`SIC_CTRL_DBG];
                    st_next.out.i2c_ctrl_sel = i_bus.wdata[`SIC_CTRL_I2C];
                    st_next.out.adc_reorder = i_bus.wdata[`SIC_CTRL_ADC];
                    st_next.out.tmr_one_master =
                        i_bus.wdata[`SIC_CTRL_TMR];
                end else if (i_bus.addr == `SIC_OFS_DMA) begin
                    // locked field drops the write entirely
                    if (!st_reg.dma_lock) begin
                        st_next.dma_mode = sic_dma_mode_t'(
                            i_bus.wdata[`SIC_DMA_MODE_LO +: 2]);
                        st_next.dma_lock = i_bus.wdata[`SIC_DMA_LOCK];
                    end
                end else if (i_bus.addr == `SIC_OFS_PWR) begin
                    // each field carries its own lock
                    if (!st_reg.stop_lock) begin
                        st_next.stop_blk = i_bus.wdata[`SIC_PWR_STOP];
                        st_next.stop_lock = i_bus.wdata[`SIC_PWR_STOP_LK];
                    end
                    if (!st_reg.wait_lock) begin
                        st_next.wait_blk = i_bus.wdata[`SIC_PWR_WAIT];
                        st_next.wait_lock = i_bus.wdata[`SIC_PWR_WAIT_LK];
                    end
                    if (!st_reg.sr12_lock) begin
                        st_next.out.sr12_standby =
                            i_bus.wdata[`SIC_PWR_SR12];
                        st_next.sr12_lock = i_bus.wdata[`SIC_PWR_SR12_LK];
                    end
                    // code 3 has no meaning, so the whole field write is
                    // dropped rather than guessing a mode
                    if (!st_reg.sr27_lock &&
                        i_bus.wdata[`SIC_PWR_SR27_LO +: 2] != 2'h3) begin
                        st_next.out.sr27_mode = sic_sr27_mode_t'(
                            i_bus.wdata[`SIC_PWR_SR27_LO +: 2]);
                        st_next.sr27_lock = i_bus.wdata[`SIC_PWR_SR27_LK];
                    end
                end
            end
            // register reads, unmapped reads return zero
            if (i_bus.rd) begin
                if (i_bus.addr == `SIC_OFS_IO_LO) begin
                    st_next.rdata = st_reg.out.io_base[15:0];
                end else if (i_bus.addr == `SIC_OFS_IO_HI) begin
                    st_next.rdata = {8'h00, st_reg.out.io_base[23:16]};
                end else if (is_scr(i_bus.addr)) begin
                    st_next.rdata = st_reg.scr[idx];
                end else if (i_bus.addr == `SIC_OFS_CTRL) begin
                    st_next.rdata = {12'h000, st_reg.out.tmr_one_master,
                                     st_reg.out.adc_reorder,
                                     st_reg.out.i2c_ctrl_sel,
                                     st_reg.dbg_always};
                end else if (i_bus.addr == `SIC_OFS_DMA) begin
                    st_next.rdata = {13'h0000, st_reg.dma_lock,
                                     st_reg.dma_mode};
                end else if (i_bus.addr == `SIC_OFS_PWR) begin
                    st_next.rdata = {7'h00, st_reg.sr27_lock,
                                     st_reg.out.sr27_mode,
                                     st_reg.sr12_lock,
                                     st_reg.out.sr12_standby,
                                     st_reg.wait_lock, st_reg.wait_blk,
                                     st_reg.stop_lock, st_reg.stop_blk};
                end else if (i_bus.addr == `SIC_OFS_STAT) begin
                    st_next.rdata = {9'h000, st_reg.out.fast_mode,
                                     st_reg.out.cause};
                end
            end
            // derived outputs follow the settings just written
            st_next.out.dbg_clk_en = st_next.dbg_always | i_tap_en;
            st_next.out.stop_enter_en = ~st_next.stop_blk;
            st_next.out.wait_enter_en = ~st_next.wait_blk;
            case (st_next.dma_mode)
                SIC_DMA_OFF: st_next.out.dma_en = 1'b0;
                SIC_DMA_RUN: st_next.out.dma_en = (i_pwr_mode == SIC_PM_RUN);
                SIC_DMA_RUN_WAIT: begin
                    st_next.out.dma_en = (i_pwr_mode != SIC_PM_STOP);
                end
                default: st_next.out.dma_en = 1'b1;
            endcase
            st_next.out.fast_mode = i_fast_mode;
            st_next.out.core_flash_div =
                i_fast_mode ? `SIC_DIV_FAST : `SIC_DIV_NORMAL;
        end
    end

    // ==========================================================
    // state register, reset handled in the next-state logic
    always_ff @(posedge i_clk_sys) begin
        st_reg <= st_next;
    end

    assign o_rdata = st_reg.rdata;
    assign o_ctl = st_reg.out;

    // ==========================================================
    // checks
    a_io_base_lo: assert property (
        @(posedge i_clk_sys) disable iff (!i_rst_n)
        (i_bus.wr && i_bus.addr == `SIC_OFS_IO_LO)
        |=> o_ctl.io_base[15:0] == $past(i_bus.wdata))
        else $error("short io base low half not stored");

    a_scratch_readback: assert property (
        @(posedge i_clk_sys) disable iff (!i_rst_n)
        (i_bus.wr && is_scr(i_bus.addr)) ##1
        (i_bus.rd && i_bus.addr == $past(i_bus.addr) && !i_bus.wr)
        |=> o_rdata == $past(i_bus.wdata, 2))
        else $error("scratch word did not read back");

    a_dbg_clk_gate: assert property (
        @(posedge i_clk_sys) disable iff (!i_rst_n)
        (st_reg.rel && !i_bus.wr && !st_reg.dbg_always)
        |=> o_ctl.dbg_clk_en == $past(i_tap_en))
        else $error("debug clock not gated by tap enable");

    a_dma_run_only: assert property (
        @(posedge i_clk_sys) disable iff (!i_rst_n)
        (st_reg.dma_mode == SIC_DMA_RUN && !i_bus.wr &&
         i_pwr_mode == SIC_PM_WAIT) |=> !o_ctl.dma_en)
        else $error("dma enabled in wait while run only");

    a_dma_lock_hold: assert property (
        @(posedge i_clk_sys) disable iff (!i_rst_n)
        (st_reg.dma_lock && i_bus.wr && i_bus.addr == `SIC_OFS_DMA)
        |=> $stable(st_reg.dma_mode) && st_reg.dma_lock)
        else $error("locked dma field changed");

    a_stop_lock_hold: assert property (
        @(posedge i_clk_sys) disable iff (!i_rst_n)
        (st_reg.stop_lock && i_bus.wr && i_bus.addr == `SIC_OFS_PWR)
        |=> $stable(o_ctl.stop_enter_en))
        else $error("locked stop field changed");

    a_sr27_code: assert property (
        @(posedge i_clk_sys) disable iff (!i_rst_n)
        o_ctl.sr27_mode != 2'h3)
        else $error("2.7v regulator in undefined mode");

    a_cause_onehot: assert property (
        @(posedge i_clk_sys) disable iff (!i_rst_n)
        $onehot0(o_ctl.cause))
        else $error("more than one reset cause shown");

    a_cause_por_wins: assert property (
        @(posedge i_clk_sys) disable iff (!i_rst_n)
        (i_rst_n && !st_reg.rel && st_reg.pend[0])
        |=> o_ctl.cause == `SIC_CAUSE_POR ##1 $stable(o_ctl.cause))
        else $error("power-on cause not captured and held");

    a_clock_ratio: assert property (
        @(posedge i_clk_sys) disable iff (!i_rst_n)
        i_fast_mode |=> o_ctl.core_flash_div == `SIC_DIV_FAST)
        else $error("fast mode ratio wrong");

    a_io_base_hi: assert property (
        @(posedge i_clk_sys) disable iff (!i_rst_n)
        (i_bus.wr && i_bus.addr == `SIC_OFS_IO_HI)
        |=> o_ctl.io_base[23:16] == $past(i_bus.wdata[7:0]))
        else $error("short io base high byte not stored");

    a_dma_all_modes: assert property (
        @(posedge i_clk_sys) disable iff (!i_rst_n)
        (st_reg.dma_mode == SIC_DMA_ALL && !i_bus.wr) |=> o_ctl.dma_en)
        else $error("dma off while enabled in all modes");

    a_dma_lock_set: assert property (
        @(posedge i_clk_sys) disable iff (!i_rst_n)
        (i_bus.wr && i_bus.addr == `SIC_OFS_DMA &&
         i_bus.wdata[`SIC_DMA_LOCK]) |=> st_reg.dma_lock)
        else $error("dma lock not taken");

    a_wait_lock_hold: assert property (
        @(posedge i_clk_sys) disable iff (!i_rst_n)
        (st_reg.wait_lock && i_bus.wr && i_bus.addr == `SIC_OFS_PWR)
        |=> $stable(o_ctl.wait_enter_en))
        else $error("locked wait field changed");

    a_sr12_lock_hold: assert property (
        @(posedge i_clk_sys) disable iff (!i_rst_n)
        (st_reg.sr12_lock && i_bus.wr && i_bus.addr == `SIC_OFS_PWR)
        |=> $stable(o_ctl.sr12_standby))
        else $error("locked 1.2v regulator field changed");

    // the next two watch the capture while reset is held
    a_por_clears: assert property (
        @(posedge i_clk_sys)
        (!i_rst_n && i_por) |=> st_reg.pend == `SIC_CAUSE_POR)
        else $error("power-on did not clear reset history");

    a_ext_after_por: assert property (
        @(posedge i_clk_sys)
        (!i_rst_n && !i_por && i_ext_rst_pin)
        |=> st_reg.pend[1] && !st_reg.pend[0])
        else $error("held reset pin not recorded over power-on");

    a_cause_held: assert property (
        @(posedge i_clk_sys) disable iff (!i_rst_n)
        (i_rst_n && st_reg.rel) |=> $stable(o_ctl.cause))
        else $error("reset cause changed outside reset");

endmodule

`default_nettype wire

// ===== core/sic_defs.svh
`ifndef SIC_DEFS_SVH
`define SIC_DEFS_SVH

// ==========================================================
// bus geometry
`define SIC_ADDR_W 5
`define SIC_DATA_W 16
`define SIC_SCR_N 8

// ==========================================================
// register offsets (word index on the plain register port)
`define SIC_OFS_IO_LO 5'h00
`define SIC_OFS_IO_HI 5'h01
`define SIC_OFS_SCR0 5'h02
`define SIC_OFS_CTRL 5'h0A
`define SIC_OFS_DMA 5'h0B
`define SIC_OFS_PWR 5'h0C
`define SIC_OFS_STAT 5'h0D

// ==========================================================
// control register fields
`define SIC_CTRL_DBG 0
`define SIC_CTRL_I2C 1
`define SIC_CTRL_ADC 2
`define SIC_CTRL_TMR 3

// dma register fields
`define SIC_DMA_MODE_LO 0
`define SIC_DMA_LOCK 2

// power register fields
`define SIC_PWR_STOP 0
`define SIC_PWR_STOP_LK 1
`define SIC_PWR_WAIT 2
`define SIC_PWR_WAIT_LK 3
`define SIC_PWR_SR12 4
`define SIC_PWR_SR12_LK 5
`define SIC_PWR_SR27_LO 6
`define SIC_PWR_SR27_LK 8

// status register fields
`define SIC_STAT_FAST 6

// ==========================================================
// reset values and constants
`define SIC_RST_IO_BASE 24'h000000
`define SIC_RST_SCR 16'h0000
`define SIC_RST_CAUSE 6'h00
`define SIC_CAUSE_POR 6'h01
`define SIC_DIV_NORMAL 3'h2
`define SIC_DIV_FAST 3'h4

`endif

// ===== core/sic_pkg.sv
package sic_pkg;
    `include "sic_defs.svh"

    // ==========================================================
    // enumerations
    typedef enum logic [1:0] {
        SIC_PM_RUN,
        SIC_PM_WAIT,
        SIC_PM_STOP
    } sic_pwr_mode_t;

    typedef enum logic [1:0] {
        SIC_DMA_OFF,
        SIC_DMA_RUN,
        SIC_DMA_RUN_WAIT,
        SIC_DMA_ALL
    } sic_dma_mode_t;

    typedef enum logic [1:0] {
        SIC_SR27_NORMAL,
        SIC_SR27_STANDBY,
        SIC_SR27_POWERDOWN
    } sic_sr27_mode_t;

    // ==========================================================
    // carriers
    typedef struct packed {
        logic [`SIC_ADDR_W-1:0] addr;
        logic [`SIC_DATA_W-1:0] wdata;
        logic wr;
        logic rd;
    } sic_bus_req_t;

    // cause bits: 0 por, 1 ext, 2 ref loss, 3 cpu, 4 sw, 5 window
    typedef struct packed {
        logic [23:0] io_base;
        logic dbg_clk_en;
        logic dma_en;
        logic stop_enter_en;
        logic wait_enter_en;
        logic sr12_standby;
        sic_sr27_mode_t sr27_mode;
        logic i2c_ctrl_sel;
        logic adc_reorder;
        logic tmr_one_master;
        logic fast_mode;
        logic [2:0] core_flash_div;
        logic [5:0] cause;
    } sic_out_t;
endpackage

// ===== tb/testbench.sv
`timescale 1ns/1ns
`default_nettype none
`include "sic_defs.svh"

// ==========================================================
// self-checking bench for the system integration control block
module testbench;
    import sic_pkg::*;

    logic clk = 1'b0; // system clock, 100 MHz
    logic rst_n = 1'b0; // synchronous reset, active low
    sic_bus_req_t bus = '0; // register port request
    sic_pwr_mode_t pm = SIC_PM_RUN; // chip power mode
    logic tap = 1'b0; // core test port enabled
    logic fast = 1'b0; // fast speed mode
    logic [5:0] src = 6'h01; // reset sources, por in bit 0
    logic [15:0] rdata; // read data
    sic_out_t ctl; // settings out
    int err_count = 0;
    int check_count = 0;
    int cyc = 0; // cycle count for the hang limit
    logic rd_q = 1'b0; // read answer due this cycle
    logic run = 1'b0; // idle read data watched debug_emulation set
    logic [15:0] exp_q[$]; // expected read data, oldest first
    logic [4:0] adr_q[$]; // address of each expected read
    logic [15:0] sv[8]; // scratch patterns
    logic [23:0] base; // short i/o base pattern
    logic [5:0] r; // reset source pattern

    always #5 clk = ~clk;

    sic_top i_sic_top (.i_clk_sys(clk), .i_rst_n(rst_n), .i_bus(bus),
        .o_rdata(rdata), .i_pwr_mode(pm), .i_tap_en(tap),
        .i_fast_mode(fast), .i_por(src[0]), .i_ext_rst_pin(src[1]),
        .i_wd_ref_loss(src[2]), .i_wd_cpu_tmo(src[3]), .i_sw_rst(src[4]),
        .i_wd_win_tmo(src[5]), .o_ctl(ctl));

    // ==========================================================
    // shared tasks
    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        check_count++;
        if (g !== e) begin
            err_count++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        @(posedge clk);
        bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    endtask

    // the expectation is queued now, the watcher compares later
    task automatic rd(input logic [4:0] a, input logic [15:0] e);
        @(posedge clk);
        bus <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
        exp_q.push_back(e);
        adr_q.push_back(a);
    endtask

    // release the port, then let settings and synced inputs land
    task automatic idle();
        @(posedge clk);
        bus <= '0;
        repeat (3) @(posedge clk);
        #1;
    endtask

    // six reset cycles: sources a for three, then b for three
    task automatic reset_with(input logic [5:0] a, input logic [5:0] b);
        @(posedge clk);
        bus <= '0;
        rst_n <= 1'b0;
        src <= a;
        repeat (3) @(posedge clk);
        src <= b;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        src <= 6'h00;
        idle();
    endtask

    task automatic cause_is(input logic [5:0] c);
        chk("cause", c, ctl.cause);
        rd(`SIC_OFS_STAT, {9'h000, fast, c});
        idle();
    endtask

    task automatic wrap_up();
        $display("checks %0d errors %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // ==========================================================
    // watcher: read data stands one cycle only, zero otherwise
    always @(posedge clk) begin
        if (rd_q) begin
            if (exp_q.size() == 0) begin
                err_count++;
                $display("BAD rdata expected none seen %h", rdata);
            end else begin
                chk($sformatf("rdata at %h", adr_q.pop_front()),
                    exp_q.pop_front(), rdata);
            end
        end else if (run) begin
            chk("rdata idle", 16'h0000, rdata);
        end
        rd_q <= bus.rd & rst_n;
    end

    // hang limit, far above the few hundred cycles of the run
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_count++;
            $display("BAD run expected end seen hang");
            wrap_up();
        end
    end

    // ==========================================================
    // main sequence
    initial begin
        void'($urandom(32'h7E9E10AB));
        r = 6'($urandom()) | 6'h01;
        reset_with(r, r);
        run = 1'b1;
        cause_is(`SIC_CAUSE_POR);
        chk("dma off", 1'b0, ctl.dma_en);
        chk("stop entry", 1'b1, ctl.stop_enter_en);
        chk("wait entry", 1'b1, ctl.wait_enter_en);
        // speed mode status and clock ratio
        for (int f = 0; f < 2; f++) begin
            @(posedge clk);
            fast <= f[0];
            idle();
            chk("fast", f[0], ctl.fast_mode);
            chk("div", f[0] ? 3'h4 : 3'h2, ctl.core_flash_div);
            rd(`SIC_OFS_STAT, {9'h000, f[0], 6'h01});
            idle();
        end
        @(posedge clk);
        fast <= 1'b0;
        // short i/o base, halves written back to back
        base = 24'($urandom());
        wr(`SIC_OFS_IO_LO, base[15:0]);
        wr(`SIC_OFS_IO_HI, {8'($urandom()), base[23:16]});
        rd(`SIC_OFS_IO_LO, base[15:0]);
        rd(`SIC_OFS_IO_HI, {8'h00, base[23:16]});
        idle();
        chk("io base", base, ctl.io_base);
        // scratch words, plus an unmapped place that keeps nothing
        for (int i = 0; i < `SIC_SCR_N; i++) begin
            sv[i] = 16'($urandom());
            wr(5'(`SIC_OFS_SCR0 + i), sv[i]);
        end
        wr(5'h1F, 16'hFFFF);
        for (int i = 0; i < `SIC_SCR_N; i++) begin
            rd(5'(`SIC_OFS_SCR0 + i), sv[i]);
        end
        rd(5'h1F, 16'h0000);
        // a write read back in the very next cycle
        sv[0] = 16'($urandom());
        wr(`SIC_OFS_SCR0, sv[0]);
        rd(`SIC_OFS_SCR0, sv[0]);
        idle();
        // control bits in every combination, bit 4 drives the tap
        for (int k = 0; k < 32; k++) begin
            wr(`SIC_OFS_CTRL, {12'($urandom()), k[3:0]});
            tap <= k[4];
            rd(`SIC_OFS_CTRL, {12'h000, k[3:0]});
            idle();
            chk("dbg clk", k[0] | k[4], ctl.dbg_clk_en);
            chk("i2c sel", k[1], ctl.i2c_ctrl_sel);
            chk("adc reorder", k[2], ctl.adc_reorder);
            chk("timer master", k[3], ctl.tmr_one_master);
        end
        // dma behaviour against each power mode
        for (int m = 0; m < 12; m++) begin
            wr(`SIC_OFS_DMA, {14'h0000, m[1:0]});
            pm <= sic_pwr_mode_t'(m[3:2]);
            rd(`SIC_OFS_DMA, {14'h0000, m[1:0]});
            idle();
            chk("dma en", (m[1:0] == 2'h3) || (m[1:0] == 2'h2 &&
                m[3:2] != 2'h2) || (m[1:0] == 2'h1 && m[3:2] == 2'h0),
                ctl.dma_en);
        end
        @(posedge clk);
        pm <= SIC_PM_RUN;
        // locked dma: the second write must be dropped
        wr(`SIC_OFS_DMA, 16'h0005);
        wr(`SIC_OFS_DMA, 16'h0003);
        rd(`SIC_OFS_DMA, 16'h0005);
        idle();
        chk("dma locked", 1'b1, ctl.dma_en);
        // power control fields, then every lock at debug_emulation
        for (int p = 0; p < 12; p++) begin
            r = {1'b0, 2'(p % 3), p[2:0]};
            wr(`SIC_OFS_PWR, {7'h00, 1'b0, r[4:3], 1'b0, r[2], 1'b0,
                r[1], 1'b0, r[0]});
            idle();
            chk("stop", !r[0], ctl.stop_enter_en);
            chk("wait", !r[1], ctl.wait_enter_en);
            chk("sr12", r[2], ctl.sr12_standby);
            chk("sr27", r[4:3], ctl.sr27_mode);
        end
        wr(`SIC_OFS_PWR, 16'h017B);
        wr(`SIC_OFS_PWR, 16'h0084);
        rd(`SIC_OFS_PWR, 16'h017B);
        idle();
        chk("stop lk", 1'b0, ctl.stop_enter_en);
        chk("wait lk", 1'b1, ctl.wait_enter_en);
        chk("sr12 lk", 1'b1, ctl.sr12_standby);
        chk("sr27 lk", 2'h1, ctl.sr27_mode);
        // each cause with random lower-priority sources beside it
        for (int k = 1; k < 6; k++) begin
            r = (6'($urandom()) << (k + 1)) | (6'h01 << k);
            reset_with(r, r);
            cause_is(6'h01 << k);
        end
        rd(`SIC_OFS_DMA, 16'h0000);
        rd(`SIC_OFS_PWR, 16'h0000);
        idle();
        // sources toggling outside reset leave the cause alone
        @(posedge clk);
        src <= 6'h3F;
        idle();
        cause_is(6'h20);
        // pin still held debug_emulation power-on has dropped
        reset_with(6'h03, 6'h02);
        cause_is(6'h02);
        idle();
        wrap_up();
    end
endmodule

`default_nettype wire
